/* File: alc_pkg.sv */
package alc_pkg;

	// ==========================================================
	// operation codes presented by the instruction decoder
	typedef enum logic [3:0] {
		ALC_OP_ADD = 4'h0,
		ALC_OP_ADD_CARRY = 4'h1,
		ALC_OP_SUB = 4'h2,
		ALC_OP_SUB_BORROW = 4'h3,
		ALC_OP_AND = 4'h4,
		ALC_OP_OR = 4'h5,
		ALC_OP_SET_BITS = 4'h6,
		ALC_OP_WORD_PLUS = 4'h7,
		ALC_OP_WORD_MINUS = 4'h8
	} alc_op_t;

	// ==========================================================
	// sequencer states, one-hot
	typedef enum logic [1:0] {
		ALC_ST_IDLE = 2'b01,
		ALC_ST_WORD_HI = 2'b10
	} alc_state_t;

	// ==========================================================
	// status flag positions and reset value
	localparam int ALC_FLAG_C = 0;
	localparam int ALC_FLAG_Z = 1;
	localparam int ALC_FLAG_N = 2;
	localparam int ALC_FLAG_V = 3;
	localparam int ALC_FLAG_S = 4;
	localparam int ALC_FLAG_H = 5;
	localparam logic [7:0] ALC_STATUS_RESET = 8'h00;

	// ==========================================================
	// i/o space
	localparam logic [5:0] ALC_IO_BIT_REACH_MAX = 6'h1F;
	localparam logic [5:0] ALC_IO_FLAG_ADDR = 6'h1E;
	localparam logic [5:0] ALC_IO_SHARED_ADDR = 6'h31;
	localparam int ALC_IO_FLAG_BITS = 4;
	localparam logic [3:0] ALC_IO_FLAG_RESET = 4'h0;
	localparam logic [7:0] ALC_OSC_TRIM_RESET = 8'h00;
	localparam logic [7:0] ALC_DEBUG_DATA_RESET = 8'h00;

endpackage : alc_pkg

/* File: alc_byte_alu.sv */
// ==========================================================
// 8-bit adder/subtractor with carry-in and flag outputs
module alc_byte_alu (
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic carry_in,
	input wire logic subtract,
	output logic [7:0] result,
	output logic carry_out,
	output logic half_carry,
	output logic overflow
);
	logic [8:0] full;
	logic [4:0] nib;

	// one 9-bit path; on subtract bit 8 is the borrow
	always_comb begin
		if (subtract) begin
			full = {1'b0, a} - {1'b0, b} - {8'h00, carry_in};
			nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, carry_in};
		end else begin
			full = {1'b0, a} + {1'b0, b} + {8'h00, carry_in};
			nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, carry_in};
		end
	end

	// signed overflow: operand signs versus result sign
	assign result = full[7:0];
	assign carry_out = full[8];
	assign half_carry = nib[4];
	assign overflow = subtract ? ((a[7] != b[7]) && (full[7] != a[7]))
		: ((a[7] == b[7]) && (full[7] != a[7]));

endmodule : alc_byte_alu

/* File: alc_w1c_bank.sv */
// ==========================================================
// sticky flags, set by hardware events, cleared by writing one
module alc_w1c_bank import alc_pkg::*; #(
	parameter int WIDTH = ALC_IO_FLAG_BITS
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] set_event,
	input wire logic clear_strobe,
	input wire logic [WIDTH-1:0] clear_mask,
	output logic [WIDTH-1:0] flags
);
	logic [WIDTH-1:0] clear_bits;

	// writing zero leaves a flag alone
	assign clear_bits = clear_strobe ? clear_mask : '0;

	// an event in the clearing cycle survives: set wins
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			flags <= WIDTH'(ALC_IO_FLAG_RESET);
		end else if (clk_en) begin
			flags <= (flags & ~clear_bits) | set_event;
		end
	end

endmodule : alc_w1c_bank

/* File: alc_core.sv */
// Summary of operation
// - add with carry: dst plus src plus C
// - word add immediate on pair, two cycles
// - subtract reg or constant, full flags
// - subtract with borrow, two registers
// - subtract immediate with borrow, one cycle
// - word subtract immediate, two cycles, flags
// - and: one cycle, only Z N V S
// - or: one cycle, Z N V S
// - set bits: or with mask constant
// - bit set/clear reach i/o 0x00-0x1F only
// - some flags clear on writing one
// - bit ops rewrite whole register
// - fuse unprogrammed: shared address hits trim
module alc_core import alc_pkg::*; (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic op_valid,
	input wire logic [3:0] op_code,
	input wire logic op_use_imm,
	input wire logic [7:0] dst_operand,
	input wire logic [7:0] source_operand,
	input wire logic [7:0] imm_operand,
	input wire logic [7:0] pair_hi_operand,
	output logic op_ready,
	output logic res_valid,
	output logic [7:0] res_data,
	output logic res_high,
	output logic [7:0] status_flags,
	input wire logic io_bit_valid,
	input wire logic io_bit_set,
	input wire logic [5:0] io_bit_addr,
	input wire logic [2:0] io_bit_index,
	output logic io_bit_refused,
	input wire logic io_wr_valid,
	input wire logic [5:0] io_wr_addr,
	input wire logic [7:0] io_wr_data,
	input wire logic [5:0] io_rd_addr,
	output logic [7:0] io_rd_data,
	input wire logic [3:0] flag_event,
	input wire logic debug_enable_fuse,
	output logic [7:0] osc_trim_register,
	output logic [7:0] debug_data_register
);
	// ==========================================================
	// declarations
	alc_state_t state;
	alc_op_t op;
	logic op_accept;
	logic [7:0] operand_b;
	logic [7:0] alu_a;
	logic [7:0] alu_b;
	logic alu_cin;
	logic alu_sub;
	logic [7:0] alu_res;
	logic alu_c;
	logic alu_h;
	logic alu_v;
	logic word_sub;
	logic lo_carry;
	logic lo_zero;
	logic [7:0] hi_hold;
	logic [7:0] next_status;
	logic fuse_meta;
	logic fuse_sync;
	logic [3:0] io_flags;
	logic bit_in_reach;
	logic bit_do;
	logic [7:0] bit_mask;
	logic [7:0] bit_cur;
	logic wr_en;
	logic [5:0] wr_addr;
	logic [7:0] wr_data;
	logic flag_clear;
	logic [7:0] logic_res;

	// ==========================================================
	// request handshake
	assign op = alc_op_t'(op_code);
	assign op_ready = (state == ALC_ST_IDLE);
	assign op_accept = op_valid && op_ready && clk_en;
	assign operand_b = op_use_imm ? imm_operand : source_operand;

	// ==========================================================
	// shared adder; the high half of a word op reuses it with b = 0
	always_comb begin
		alu_a = dst_operand;
		alu_b = operand_b;
		alu_cin = 1'b0;
		alu_sub = 1'b0;
		case (state)
			ALC_ST_WORD_HI: begin
				alu_a = hi_hold;
				alu_b = 8'h00;
				alu_cin = lo_carry;
				alu_sub = word_sub;
			end
			default: begin
				case (op)
					ALC_OP_ADD_CARRY: alu_cin = status_flags[ALC_FLAG_C];
					ALC_OP_SUB: alu_sub = 1'b1;
					ALC_OP_SUB_BORROW: begin
						alu_sub = 1'b1;
						alu_cin = status_flags[ALC_FLAG_C];
					end
					ALC_OP_WORD_PLUS: alu_b = imm_operand;
					ALC_OP_WORD_MINUS: begin
						alu_b = imm_operand;
						alu_sub = 1'b1;
					end
					default: alu_sub = 1'b0;
				endcase
			end
		endcase
	end

	alc_byte_alu u_alu (
		.a(alu_a),
		.b(alu_b),
		.carry_in(alu_cin),
		.subtract(alu_sub),
		.result(alu_res),
		.carry_out(alu_c),
		.half_carry(alu_h),
		.overflow(alu_v)
	);

	// ==========================================================
	// sequencer: word ops hold the core for a second cycle
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state <= ALC_ST_IDLE;
		end else if (clk_en) begin
			case (state)
				ALC_ST_IDLE: begin
					if (op_accept && (op == ALC_OP_WORD_PLUS || op == ALC_OP_WORD_MINUS)) begin
						state <= ALC_ST_WORD_HI;
					end
				end
				ALC_ST_WORD_HI: state <= ALC_ST_IDLE;
				default: state <= ALC_ST_IDLE;
			endcase
		end
	end

	// low-half carry, zero and high byte kept for the second cycle
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			lo_carry <= 1'b0;
			lo_zero <= 1'b0;
			hi_hold <= 8'h00;
			word_sub <= 1'b0;
		end else if (clk_en && op_accept) begin
			lo_carry <= alu_c;
			lo_zero <= (alu_res == 8'h00);
			hi_hold <= pair_hi_operand;
			word_sub <= (op == ALC_OP_WORD_MINUS);
		end
	end

	// ==========================================================
	// result write-back to the register file
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			res_valid <= 1'b0;
			res_data <= 8'h00;
			res_high <= 1'b0;
		end else if (clk_en) begin
			res_valid <= op_accept || (state == ALC_ST_WORD_HI);
			res_high <= (state == ALC_ST_WORD_HI);
			if (state == ALC_ST_WORD_HI) begin
				res_data <= alu_res;
			end else if (op_accept) begin
				case (op)
					ALC_OP_AND: res_data <= dst_operand & operand_b;
					ALC_OP_OR: res_data <= dst_operand | operand_b;
					ALC_OP_SET_BITS: res_data <= dst_operand | imm_operand;
					default: res_data <= alu_res;
				endcase
			end
		end
	end

	// logic-family result; set-bits always takes the immediate, whatever op_use_imm says
	assign logic_res = (op == ALC_OP_AND) ? (dst_operand & operand_b)
		: (op == ALC_OP_SET_BITS) ? (dst_operand | imm_operand) : (dst_operand | operand_b);

	// ==========================================================
	// status flags; S is always N xor V
	always_comb begin
		next_status = status_flags;
		if (state == ALC_ST_WORD_HI) begin
			next_status[ALC_FLAG_C] = alu_c;
			next_status[ALC_FLAG_Z] = lo_zero && (alu_res == 8'h00);
			next_status[ALC_FLAG_N] = alu_res[7];
			next_status[ALC_FLAG_V] = alu_v;
			next_status[ALC_FLAG_S] = alu_res[7] ^ alu_v;
		end else if (op_accept) begin
			case (op)
				ALC_OP_AND, ALC_OP_OR, ALC_OP_SET_BITS: begin
					// logic ops leave C and H alone
					next_status[ALC_FLAG_V] = 1'b0;
					next_status[ALC_FLAG_N] = logic_res[7];
					next_status[ALC_FLAG_Z] = (logic_res == 8'h00);
					next_status[ALC_FLAG_S] = next_status[ALC_FLAG_N];
				end
				ALC_OP_WORD_PLUS, ALC_OP_WORD_MINUS: next_status = status_flags;
				default: begin
					next_status[ALC_FLAG_C] = alu_c;
					next_status[ALC_FLAG_H] = alu_h;
					next_status[ALC_FLAG_N] = alu_res[7];
					next_status[ALC_FLAG_V] = alu_v;
					next_status[ALC_FLAG_S] = alu_res[7] ^ alu_v;
					// borrow chains keep Z only if all bytes were zero
					next_status[ALC_FLAG_Z] = (op == ALC_OP_SUB_BORROW)
						? (status_flags[ALC_FLAG_Z] && alu_res == 8'h00)
						: (alu_res == 8'h00);
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			status_flags <= ALC_STATUS_RESET;
		end else if (clk_en) begin
			status_flags <= next_status;
		end
	end

	// ==========================================================
	// fuse level comes from outside: two flops before use
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			fuse_meta <= 1'b0;
			fuse_sync <= 1'b0;
		end else if (clk_en) begin
			fuse_meta <= debug_enable_fuse;
			fuse_sync <= fuse_meta;
		end
	end

	// ==========================================================
	// i/o view; reserved flag bits read as zero
	function automatic logic [7:0] io_view(input logic [5:0] addr);
		logic [7:0] v;
		v = 8'h00;
		if (addr == ALC_IO_FLAG_ADDR) begin
			v = {4'h0, io_flags};
		end else if (addr == ALC_IO_SHARED_ADDR) begin
			v = fuse_sync ? debug_data_register : osc_trim_register;
		end
		return v;
	endfunction : io_view

	// bit ops beyond the low 32 addresses are refused
	assign bit_in_reach = (io_bit_addr <= ALC_IO_BIT_REACH_MAX);
	assign bit_do = io_bit_valid && bit_in_reach;
	assign bit_mask = 8'h01 << io_bit_index;
	// a process, not an assign: the view reads flags and registers beyond its argument
	always_comb begin
		bit_cur = io_view(io_bit_addr);
	end

	// one write port; a bit op wins over a plain write in the same cycle
	always_comb begin
		wr_en = io_wr_valid;
		wr_addr = io_wr_addr;
		wr_data = io_wr_data;
		if (bit_do) begin
			wr_en = 1'b1;
			wr_addr = io_bit_addr;
			// whole register written back: set flags go out as ones
			wr_data = io_bit_set ? (bit_cur | bit_mask) : (bit_cur & ~bit_mask);
		end
	end

	assign flag_clear = wr_en && (wr_addr == ALC_IO_FLAG_ADDR);

	alc_w1c_bank #(
		.WIDTH(ALC_IO_FLAG_BITS)
	) u_flags (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.set_event(flag_event),
		.clear_strobe(flag_clear),
		.clear_mask(wr_data[3:0]),
		.flags(io_flags)
	);

	// shared address steered by the synchronised fuse
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			osc_trim_register <= ALC_OSC_TRIM_RESET;
			debug_data_register <= ALC_DEBUG_DATA_RESET;
		end else if (clk_en && wr_en && wr_addr == ALC_IO_SHARED_ADDR) begin
			if (fuse_sync) begin
				debug_data_register <= wr_data;
			end else begin
				osc_trim_register <= wr_data;
			end
		end
	end

	// read data and refusal pulse, registered
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			io_rd_data <= 8'h00;
			io_bit_refused <= 1'b0;
		end else if (clk_en) begin
			io_rd_data <= io_view(io_rd_addr);
			io_bit_refused <= io_bit_valid && !bit_in_reach;
		end
	end

	// ==========================================================
	// checks
	logic [7:0] chk_adc;
	logic [7:0] chk_sbc;
	logic [7:0] chk_and;
	logic [7:0] chk_set;
	assign chk_adc = dst_operand + operand_b + {7'h00, status_flags[ALC_FLAG_C]};
	assign chk_sbc = dst_operand - operand_b - {7'h00, status_flags[ALC_FLAG_C]};
	assign chk_and = dst_operand & operand_b;
	assign chk_set = dst_operand | imm_operand;

	property p_adc_sum;
		@(posedge sys_clk) disable iff (!reset_n)
		op_accept && op == ALC_OP_ADD_CARRY |=> res_valid && res_data == $past(chk_adc);
	endproperty
	a_adc_sum: assert property (p_adc_sum) else $error("add with carry wrong");

	property p_word_plus;
		@(posedge sys_clk) disable iff (!reset_n)
		op_accept && op == ALC_OP_WORD_PLUS ##1 clk_en
			|-> !op_ready && res_valid && !res_high ##1 res_valid && res_high && op_ready;
	endproperty
	a_word_plus: assert property (p_word_plus) else $error("word add not two cycles");

	property p_sub_flags;
		@(posedge sys_clk) disable iff (!reset_n)
		op_accept && op == ALC_OP_SUB |=> status_flags[ALC_FLAG_Z] == (res_data == 8'h00)
			&& status_flags[ALC_FLAG_N] == res_data[7];
	endproperty
	a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

	property p_sbc_reg;
		@(posedge sys_clk) disable iff (!reset_n)
		op_accept && op == ALC_OP_SUB_BORROW && !op_use_imm |=> res_data == $past(chk_sbc);
	endproperty
	a_sbc_reg: assert property (p_sbc_reg) else $error("borrow subtract wrong");

	property p_sbc_imm;
		@(posedge sys_clk) disable iff (!reset_n)
		op_accept && op == ALC_OP_SUB_BORROW && op_use_imm |=> res_data == $past(chk_sbc);
	endproperty
	a_sbc_imm: assert property (p_sbc_imm) else $error("borrow immediate wrong");

	property p_word_minus;
		@(posedge sys_clk) disable iff (!reset_n)
		op_accept && op == ALC_OP_WORD_MINUS ##1 clk_en ##1 clk_en
			|-> res_high && status_flags[ALC_FLAG_S]
			== (status_flags[ALC_FLAG_N] ^ status_flags[ALC_FLAG_V])
			&& status_flags[ALC_FLAG_N] == res_data[7]
			&& (!status_flags[ALC_FLAG_Z] || res_data == 8'h00);
	endproperty
	a_word_minus: assert property (p_word_minus) else $error("word subtract wrong");

	property p_and_logic;
		@(posedge sys_clk) disable iff (!reset_n)
		op_accept && op == ALC_OP_AND |=> res_data == $past(chk_and)
			&& !status_flags[ALC_FLAG_V] && $stable(status_flags[ALC_FLAG_C]);
	endproperty
	a_and_logic: assert property (p_and_logic) else $error("and wrong");

	property p_set_bits;
		@(posedge sys_clk) disable iff (!reset_n)
		op_accept && (op == ALC_OP_SET_BITS || (op == ALC_OP_OR && op_use_imm))
			|=> res_data == $past(chk_set) && !status_flags[ALC_FLAG_V];
	endproperty
	a_set_bits: assert property (p_set_bits) else $error("or mask wrong");

	property p_bit_reach;
		@(posedge sys_clk) disable iff (!reset_n)
		clk_en && io_bit_valid && io_bit_addr > ALC_IO_BIT_REACH_MAX |=> io_bit_refused;
	endproperty
	a_bit_reach: assert property (p_bit_reach) else $error("far bit op not refused");

	property p_w1c;
		@(posedge sys_clk) disable iff (!reset_n)
		clk_en && flag_clear && wr_data[0] && !flag_event[0] |=> !io_flags[0];
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

	property p_rmw;
		@(posedge sys_clk) disable iff (!reset_n)
		clk_en && bit_do && io_bit_set && io_bit_addr == ALC_IO_FLAG_ADDR
			&& flag_event == 4'h0 |=> io_flags == 4'h0;
	endproperty
	a_rmw: assert property (p_rmw) else $error("bit op kept set flags");

	property p_shared;
		@(posedge sys_clk) disable iff (!reset_n)
		clk_en && !fuse_sync && wr_en && wr_addr == ALC_IO_SHARED_ADDR
			|=> osc_trim_register == $past(wr_data) && $stable(debug_data_register);
	endproperty
	a_shared: assert property (p_shared) else $error("shared address misrouted");

	c_adc: cover property (@(posedge sys_clk) op_accept && op == ALC_OP_ADD_CARRY);
	c_word: cover property (@(posedge sys_clk) res_valid && res_high);
	c_refused: cover property (@(posedge sys_clk) io_bit_refused);
	c_flag_clear: cover property (@(posedge sys_clk) flag_clear && io_flags != 4'h0);

endmodule : alc_core

/* File: alc_decoder_model.sv */
// ==========================================================
// decoder and register file stand-in: one request at a time,
// held until the core takes it, results written back to a pair
module alc_decoder_model (
	input wire logic sys_clk,
	input wire logic op_ready,
	input wire logic res_valid,
	input wire logic res_high,
	input wire logic [7:0] res_data,
	output logic op_valid,
	output logic [3:0] op_code,
	output logic op_use_imm,
	output logic [7:0] dst_operand,
	output logic [7:0] source_operand,
	output logic [7:0] imm_operand,
	output logic [7:0] pair_hi_operand
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] pair_file;
	// idle at time zero
	initial begin
		op_valid = 1'b0;
		op_code = 4'h0;
		op_use_imm = 1'b0;
		dst_operand = 8'h00;
		source_operand = 8'h00;
		imm_operand = 8'h00;
		pair_hi_operand = 8'h00;
	end
	// write-back of each result byte into the destination pair
	always @(posedge sys_clk) begin
		if (res_valid === 1'b1 && res_high === 1'b1)
			pair_file[15:8] <= res_data;
		else if (res_valid === 1'b1)
			pair_file[7:0] <= res_data;
	end
	// called at a falling edge; returns at the falling edge after the take
	task automatic issue(input logic [3:0] code, input logic use_imm, input logic [7:0] dst,
		input logic [7:0] src, input logic [7:0] imm, input logic [7:0] hi);
		op_code = code;
		op_use_imm = use_imm;
		dst_operand = dst;
		source_operand = src;
		imm_operand = imm;
		pair_hi_operand = hi;
		op_valid = 1'b1;
		while (op_ready !== 1'b1)
			@(negedge sys_clk);
		@(negedge sys_clk);
	endtask : issue
	// dropped request: stale dst and immediate operands are scrambled so nothing leans on them
	task automatic idle();
		op_valid = 1'b0;
		dst_operand = ~dst_operand;
		imm_operand = ~imm_operand;
	endtask : idle
endmodule : alc_decoder_model

/* File: alc_core_bench.sv */
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module alc_core_bench import alc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic op_valid, op_use_imm, op_ready, res_valid, res_high, io_bit_refused;
	logic [3:0] op_code;
	logic [7:0] dst_operand, source_operand, imm_operand, pair_hi_operand, res_data;
	logic [7:0] status_flags, io_rd_data, osc_trim_register, debug_data_register;
	logic io_bit_valid = 1'b0;
	logic io_bit_set = 1'b0;
	logic [5:0] io_bit_addr = 6'h00;
	logic [2:0] io_bit_index = 3'h0;
	logic io_wr_valid = 1'b0;
	logic [5:0] io_wr_addr = 6'h00;
	logic [7:0] io_wr_data = 8'h00;
	logic [5:0] io_rd_addr = 6'h00;
	logic [3:0] flag_event = 4'h0;
	logic debug_enable_fuse = 1'b0;
	logic [7:0] exp_flags = 8'h00;
	int miscompares = 0;
	int n_tests = 0;

	// ==========================================================
	// clock, core and decoder stand-in
	always #25 sys_clk = ~sys_clk;
	alc_core dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .op_valid(op_valid),
		.op_code(op_code), .op_use_imm(op_use_imm), .dst_operand(dst_operand),
		.source_operand(source_operand), .imm_operand(imm_operand),
		.pair_hi_operand(pair_hi_operand), .op_ready(op_ready), .res_valid(res_valid),
		.res_data(res_data), .res_high(res_high), .status_flags(status_flags),
		.io_bit_valid(io_bit_valid), .io_bit_set(io_bit_set), .io_bit_addr(io_bit_addr),
		.io_bit_index(io_bit_index), .io_bit_refused(io_bit_refused),
		.io_wr_valid(io_wr_valid), .io_wr_addr(io_wr_addr), .io_wr_data(io_wr_data),
		.io_rd_addr(io_rd_addr), .io_rd_data(io_rd_data), .flag_event(flag_event),
		.debug_enable_fuse(debug_enable_fuse), .osc_trim_register(osc_trim_register),
		.debug_data_register(debug_data_register));
	alc_decoder_model dec (.sys_clk(sys_clk), .op_ready(op_ready), .res_valid(res_valid),
		.res_high(res_high), .res_data(res_data), .op_valid(op_valid), .op_code(op_code),
		.op_use_imm(op_use_imm), .dst_operand(dst_operand), .source_operand(source_operand),
		.imm_operand(imm_operand), .pair_hi_operand(pair_hi_operand));

	// ==========================================================
	// reference byte operation: returns {flags, result}
	function automatic logic [15:0] ref_byte(input logic [3:0] op, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] f);
		logic [8:0] w;
		logic [4:0] h;
		logic [7:0] r;
		logic ci;
		logic [7:0] nf;
		ci = (op == 4'h1 || op == 4'h3) ? f[ALC_FLAG_C] : 1'b0;
		nf = f;
		if (op <= 4'h1) begin
			w = a + b + ci;
			h = a[3:0] + b[3:0] + ci;
			r = w[7:0];
			nf[ALC_FLAG_V] = (a[7] == b[7]) && (r[7] != a[7]);
		end else if (op <= 4'h3) begin
			w = {1'b0, a} - b - ci;
			h = {1'b0, a[3:0]} - b[3:0] - ci;
			r = w[7:0];
			nf[ALC_FLAG_V] = (a[7] != b[7]) && (r[7] != a[7]);
		end else begin
			// logic ops keep carry and half-carry
			r = (op == 4'h4) ? (a & b) : (a | b);
			w = {f[ALC_FLAG_C], r};
			h = {f[ALC_FLAG_H], 4'h0};
			nf[ALC_FLAG_V] = 1'b0;
		end
		nf[ALC_FLAG_C] = w[8];
		nf[ALC_FLAG_H] = h[4];
		nf[ALC_FLAG_N] = r[7];
		nf[ALC_FLAG_S] = nf[ALC_FLAG_N] ^ nf[ALC_FLAG_V];
		// borrow chains zero across bytes, so it can only stay set
		nf[ALC_FLAG_Z] = (r == 8'h00) && (op != 4'h3 || f[ALC_FLAG_Z]);
		return {nf, r};
	endfunction : ref_byte

	// ==========================================================
	// scenarios
	task automatic t_bytes();
		logic [3:0] ops[14] = '{4'h2, 4'h3, 4'h2, 4'h1, 4'h2, 4'h3, 4'h2, 4'h3, 4'h4, 4'h4,
			4'h5, 4'h5, 4'h6, 4'h0};
		logic im[14] = '{0, 0, 1, 0, 1, 0, 1, 1, 0, 1, 0, 1, 1, 0};
		logic [7:0] av[14] = '{8'h00, 8'h20, 8'h00, 8'h7F, 8'h80, 8'h10, 8'h05, 8'h00, 8'hF0,
			8'h81, 8'h00, 8'h40, 8'h00, 8'h0F};
		logic [7:0] bv[14] = '{8'h01, 8'h0F, 8'h01, 8'h00, 8'h01, 8'h10, 8'h05, 8'h00, 8'h3C,
			8'h80, 8'h00, 8'h01, 8'h81, 8'h01};
		logic [15:0] e;
		// back to back: the request stays up between operations
		for (int i = 0; i < 14; i++) begin
			e = ref_byte(ops[i], av[i], bv[i], exp_flags);
			dec.issue(ops[i], im[i], av[i], im[i] ? ~bv[i] : bv[i], im[i] ? bv[i] : ~bv[i], 8'h00);
			`CHK(res_valid, 1'b1)
			`CHK(res_data, e[7:0])
			`CHK(status_flags, e[15:8])
			exp_flags = e[15:8];
		end
		dec.idle();
	endtask : t_bytes

	task automatic t_word(input logic [3:0] op, input logic [15:0] p, input logic [7:0] k);
		logic [16:0] w;
		logic [7:0] f;
		w = (op == ALC_OP_WORD_PLUS) ? {1'b0, p} + k : {1'b0, p} - k;
		f = exp_flags;
		f[ALC_FLAG_C] = w[16];
		f[ALC_FLAG_Z] = (w[15:0] == 16'h0000);
		f[ALC_FLAG_N] = w[15];
		f[ALC_FLAG_V] = (op == ALC_OP_WORD_PLUS) ? (~p[15] & w[15]) : (p[15] & ~w[15]);
		f[ALC_FLAG_S] = f[ALC_FLAG_N] ^ f[ALC_FLAG_V];
		// the held request during the high cycle must be refused, not queued
		dec.issue(op, 1'b1, p[7:0], 8'h5A, k, p[15:8]);
		`CHK({res_valid, res_high, op_ready}, 3'b100)
		`CHK(res_data, w[7:0])
		@(negedge sys_clk);
		`CHK({res_valid, res_high, op_ready}, 3'b111)
		`CHK(res_data, w[15:8])
		`CHK(status_flags, f)
		exp_flags = f;
	endtask : t_word

	task automatic io_write(input logic [5:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		io_wr_addr = a;
		io_wr_data = d;
		io_wr_valid = 1'b1;
		@(negedge sys_clk);
		io_wr_valid = 1'b0;
		io_wr_data = ~d;
	endtask : io_write

	task automatic io_bit(input logic [5:0] a, input logic [2:0] n, input logic s,
		input logic rf);
		@(negedge sys_clk);
		io_bit_addr = a;
		io_bit_index = n;
		io_bit_set = s;
		io_bit_valid = 1'b1;
		@(negedge sys_clk);
		io_bit_valid = 1'b0;
		`CHK(io_bit_refused, rf)
	endtask : io_bit

	task automatic io_read(input logic [5:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		io_rd_addr = a;
		@(negedge sys_clk);
		`CHK(io_rd_data, e)
	endtask : io_read

	task automatic events(input logic [3:0] ev);
		@(negedge sys_clk);
		flag_event = ev;
		@(negedge sys_clk);
		flag_event = 4'h0;
	endtask : events

	task automatic t_flags();
		events(4'h5);
		io_read(ALC_IO_FLAG_ADDR, 8'h05);
		// reserved upper bits written as zero
		io_write(ALC_IO_FLAG_ADDR, 8'h04);
		io_read(ALC_IO_FLAG_ADDR, 8'h01);
		events(4'h4);
		io_bit(ALC_IO_FLAG_ADDR, 3'h3, 1'b1, 1'b0);
		io_read(ALC_IO_FLAG_ADDR, 8'h00);
		events(4'h2);
		io_bit(ALC_IO_FLAG_ADDR, 3'h0, 1'b0, 1'b0);
		io_read(ALC_IO_FLAG_ADDR, 8'h00);
		// at 0x3E, well past the reach: refused, and the flags stay untouched
		events(4'h8);
		io_bit(6'h3E, 3'h3, 1'b1, 1'b1);
		io_read(ALC_IO_FLAG_ADDR, 8'h08);
		io_bit(ALC_IO_BIT_REACH_MAX, 3'h0, 1'b1, 1'b0);
	endtask : t_flags

	task automatic t_shared();
		// only the shared address is written; reserved addresses are left alone
		io_write(ALC_IO_SHARED_ADDR, 8'hA5);
		`CHK({osc_trim_register, debug_data_register}, 16'hA500)
		io_read(ALC_IO_SHARED_ADDR, 8'hA5);
		debug_enable_fuse = 1'b1;
		repeat (3) @(negedge sys_clk);
		io_write(ALC_IO_SHARED_ADDR, 8'h3C);
		`CHK({osc_trim_register, debug_data_register}, 16'hA53C)
		io_read(ALC_IO_SHARED_ADDR, 8'h3C);
		// a frozen core ignores the write strobe
		clk_en = 1'b0;
		io_write(ALC_IO_SHARED_ADDR, 8'h00);
		clk_en = 1'b1;
		`CHK({osc_trim_register, debug_data_register}, 16'hA53C)
	endtask : t_shared

	// ==========================================================
	// verdict, reached from the main sequence or the watchdog
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	// the whole run is under a hundred cycles; this leaves ample slack
	initial begin
		repeat (5000) @(posedge sys_clk);
		miscompares++;
		report_and_stop();
	end

	initial begin
		repeat (20) @(negedge sys_clk);
		reset_n = 1'b1;
		@(negedge sys_clk);
		`CHK({op_ready, res_valid, status_flags}, 10'h200)
		t_bytes();
		@(negedge sys_clk);
		t_word(ALC_OP_WORD_PLUS, 16'h00FF, 8'h01);
		t_word(ALC_OP_WORD_MINUS, 16'h0000, 8'h01);
		t_word(ALC_OP_WORD_MINUS, 16'h8000, 8'h01);
		dec.idle();
		@(negedge sys_clk);
		`CHK(dec.pair_file, 16'h7FFF)
		t_flags();
		t_shared();
		report_and_stop();
	end
endmodule : alc_core_bench
